// *** rtl/dmace_engine.sv ***
// Notes on behaviour
// - five channels, each with its own request input, all through one arbiter
// - each channel moves up to 131071 items per transfer
// - higher software level wins; on a tie the lower channel number wins
// - memory and peripheral item widths are 8, 16 or 32 bits, independently
// - each side has its own fixed or incrementing address mode
// - directions: peripheral to memory, memory to peripheral, memory to memory
// - one interrupt output per channel from three flagged events
// - one register port for setup, two bus master ports for data
// - every item is a source read followed by a destination write
// - each access moves exactly that side's item width in bytes
// - narrower destination gets only the low bytes of the read value
// - wider destination gets the read value zero extended
// - incrementing side advances by 1, 2 or 4 bytes per item
// - load count before enabling; count reads back as items still left
// - clearing channel enable stops further items
// - re-enable without reprogramming resumes at current count and addresses, unless a bus error halted the channel, which then moves nothing
// - writing count or either base before re-enable starts a fresh transfer
// - a finished channel re-enabled without reprogramming moves nothing
// - peripheral raises request; engine acks once its peripheral access completes
// - circular mode reloads count, flags full and keeps serving until disabled
// - memory-to-memory starts on enable without a request, ends at zero
// - full, half and error flags each have clear and enable bits
//
// The implementer's own choices: the address-and-strobe port and the register addresses.
`include "dmace_params.svh"
`default_nettype none
module dmace_engine #(
    parameter int N = `DMACE_CHANNELS
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [`DMACE_ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic [N-1:0] periph_request,
    output logic [N-1:0] periph_ack,
    output logic [N-1:0] channel_irq,
    output logic mbus_req,
    output logic mbus_write,
    output logic [1:0] mbus_size,
    output logic [31:0] mbus_addr,
    output logic [31:0] mbus_wdata,
    input wire logic mbus_ready,
    input wire logic [31:0] mbus_rdata,
    input wire logic mbus_error,
    output logic pbus_req,
    output logic pbus_write,
    output logic [1:0] pbus_size,
    output logic [31:0] pbus_addr,
    output logic [31:0] pbus_wdata,
    input wire logic pbus_ready,
    input wire logic [31:0] pbus_rdata,
    input wire logic pbus_error
);
    dmace_pkg::dmace_regs_t r_reg, r_next;
    logic [N-1:0] elig;
    logic [N-1:0][1:0] level;
    logic arb_any;
    logic [2:0] grant;
    logic [2:0] ch;
    logic [`DMACE_CTL_W-1:0] c;
    logic src_is_p, src_mem_port, dst_mem_port, cur_mem_port;
    logic [1:0] srcw, dstw, pw, mw;
    logic [31:0] src_addr, dst_addr, rdv, rd_data, item_val;
    logic done, err;
    logic [3:0] wsel;
    logic wok;
    logic [`DMACE_CNT_W-1:0] left;

    always_comb begin
        for (int i = 0; i < N; i++) begin
            level[i] = r_reg.ctl[i][`DMACE_CTL_SW_PRIORITY_LEVEL +: 2];
            elig[i] = r_reg.ctl[i][`DMACE_CTL_EN] && !r_reg.halt[i]
                && r_reg.remain[i] != '0
                && (r_reg.ctl[i][`DMACE_CTL_M2M] || periph_request[i]);
            channel_irq[i] = |(r_reg.flg[i]
                & r_reg.ctl[i][`DMACE_CTL_ERR_IE:`DMACE_CTL_FULL_IE]);
        end
    end

    dmace_arbiter #(.N(N)) u_arb (
        .eligible(elig),
        .level(level),
        .any(arb_any),
        .grant(grant)
    );

    dmace_regread #(.N(N)) u_rd (
        .addr(reg_addr),
        .flg(r_reg.flg),
        .ctl(r_reg.ctl),
        .remain(r_reg.remain),
        .pbase(r_reg.pbase),
        .mbase(r_reg.mbase),
        .data(rd_data)
    );

    // path selection for the channel being started or in flight
    assign ch = (r_reg.st == dmace_pkg::st_idle) ? grant : r_reg.sel;
    assign c = r_reg.ctl[ch];
    assign pw = c[`DMACE_CTL_PW +: 2];
    assign mw = c[`DMACE_CTL_MW +: 2];
    assign src_is_p = !c[`DMACE_CTL_DIR];
    assign src_mem_port = c[`DMACE_CTL_M2M] || !src_is_p;
    assign dst_mem_port = c[`DMACE_CTL_M2M] || src_is_p;
    assign srcw = src_is_p ? pw : mw;
    assign dstw = src_is_p ? mw : pw;
    assign src_addr = src_is_p ? r_reg.pcur[ch] : r_reg.mcur[ch];
    assign dst_addr = src_is_p ? r_reg.mcur[ch] : r_reg.pcur[ch];
    assign cur_mem_port = (r_reg.st == dmace_pkg::st_read) ? src_mem_port : dst_mem_port;
    assign done = cur_mem_port ? (r_reg.mreq && mbus_ready) : (r_reg.preq && pbus_ready);
    assign err = cur_mem_port ? mbus_error : pbus_error;
    assign rdv = cur_mem_port ? mbus_rdata : pbus_rdata;
    // masking both ways gives truncation and zero extension in one step
    assign item_val = rdv & dmace_pkg::item_mask(srcw) & dmace_pkg::item_mask(dstw);
    assign wsel = reg_addr[7:4] - 4'h1;
    assign wok = reg_addr[7:4] != 4'h0 && wsel < 4'(N) && reg_addr[1:0] == 2'h0;
    assign left = r_reg.remain[ch] - `DMACE_CNT_W'(1);

    always_comb begin
        r_next = r_reg;
        r_next.ack = '0;
        r_next.rdata = reg_rd ? rd_data : 32'h0000_0000;
        if (reg_wr && reg_addr == `DMACE_OFS_CLEAR) begin
            for (int i = 0; i < N; i++) begin
                r_next.flg[i] = r_reg.flg[i] & ~reg_wdata[i*`DMACE_FLG_STRIDE +: 3];
            end
        end else if (reg_wr && wok) begin
            case (reg_addr[3:2])
                `DMACE_SUB_CTL: begin
                    r_next.ctl[wsel[2:0]] = reg_wdata[`DMACE_CTL_W-1:0];
                    // reload only on a fresh start; otherwise resume where it stopped
                    if (reg_wdata[`DMACE_CTL_EN] && !r_reg.ctl[wsel[2:0]][`DMACE_CTL_EN]
                        && r_reg.pend[wsel[2:0]]) begin
                        r_next.remain[wsel[2:0]] = r_reg.cprog[wsel[2:0]];
                        r_next.pcur[wsel[2:0]] = r_reg.pbase[wsel[2:0]];
                        r_next.mcur[wsel[2:0]] = r_reg.mbase[wsel[2:0]];
                        r_next.pend[wsel[2:0]] = 1'b0;
                        r_next.halt[wsel[2:0]] = 1'b0;
                    end
                end
                `DMACE_SUB_CNT: begin
                    r_next.cprog[wsel[2:0]] = reg_wdata[`DMACE_CNT_W-1:0];
                    r_next.pend[wsel[2:0]] = 1'b1;
                end
                `DMACE_SUB_PBASE: begin
                    r_next.pbase[wsel[2:0]] = reg_wdata;
                    r_next.pend[wsel[2:0]] = 1'b1;
                end
                default: begin
                    r_next.mbase[wsel[2:0]] = reg_wdata;
                    r_next.pend[wsel[2:0]] = 1'b1;
                end
            endcase
        end
        case (r_reg.st)
            dmace_pkg::st_idle: begin
                if (arb_any) begin
                    r_next.sel = grant;
                    r_next.st = dmace_pkg::st_read;
                    if (src_mem_port) begin
                        r_next.mreq = 1'b1;
                        r_next.mwr = 1'b0;
                        r_next.maddr = src_addr;
                        r_next.msize = srcw;
                    end else begin
                        r_next.preq = 1'b1;
                        r_next.pwr = 1'b0;
                        r_next.paddr = src_addr;
                        r_next.psize = srcw;
                    end
                end
            end
            dmace_pkg::st_read, dmace_pkg::st_write: begin
                if (done) begin
                    r_next.mreq = 1'b0;
                    r_next.preq = 1'b0;
                    if (!cur_mem_port) begin
                        r_next.ack[ch] = 1'b1;
                    end
                    if (err) begin
                        r_next.flg[ch][`DMACE_FLG_ERR] = 1'b1;
                        r_next.ctl[ch][`DMACE_CTL_EN] = 1'b0;
                        r_next.halt[ch] = 1'b1;
                        r_next.st = dmace_pkg::st_idle;
                    end else if (r_reg.st == dmace_pkg::st_read) begin
                        r_next.st = dmace_pkg::st_write;
                        if (dst_mem_port) begin
                            r_next.mreq = 1'b1;
                            r_next.mwr = 1'b1;
                            r_next.maddr = dst_addr;
                            r_next.msize = dstw;
                            r_next.mwdata = item_val;
                        end else begin
                            r_next.preq = 1'b1;
                            r_next.pwr = 1'b1;
                            r_next.paddr = dst_addr;
                            r_next.psize = dstw;
                            r_next.pwdata = item_val;
                        end
                    end else begin
                        r_next.st = dmace_pkg::st_update;
                    end
                end
            end
            dmace_pkg::st_update: begin
                r_next.st = dmace_pkg::st_idle;
                r_next.remain[ch] = left;
                if (c[`DMACE_CTL_PINC]) begin
                    r_next.pcur[ch] = r_reg.pcur[ch] + dmace_pkg::item_bytes(pw);
                end
                if (c[`DMACE_CTL_MINC]) begin
                    r_next.mcur[ch] = r_reg.mcur[ch] + dmace_pkg::item_bytes(mw);
                end
                if (left == (r_reg.cprog[ch] >> 1)) begin
                    r_next.flg[ch][`DMACE_FLG_HALF] = 1'b1;
                end
                if (left == '0) begin
                    r_next.flg[ch][`DMACE_FLG_FULL] = 1'b1;
                    if (c[`DMACE_CTL_CIRC]) begin
                        r_next.remain[ch] = r_reg.cprog[ch];
                        r_next.pcur[ch] = r_reg.pbase[ch];
                        r_next.mcur[ch] = r_reg.mbase[ch];
                    end
                end
            end
            default: r_next.st = dmace_pkg::st_idle;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign reg_rdata = r_reg.rdata;
    assign periph_ack = r_reg.ack;
    assign mbus_req = r_reg.mreq;
    assign mbus_write = r_reg.mwr;
    assign mbus_size = r_reg.msize;
    assign mbus_addr = r_reg.maddr;
    assign mbus_wdata = r_reg.mwdata;
    assign pbus_req = r_reg.preq;
    assign pbus_write = r_reg.pwr;
    assign pbus_size = r_reg.psize;
    assign pbus_addr = r_reg.paddr;
    assign pbus_wdata = r_reg.pwdata;

    // checks
    logic sw_priority_level_ok;
    always_comb begin
        sw_priority_level_ok = 1'b1;
        for (int i = 0; i < N; i++) begin
            if (elig[i] && (level[i] > level[grant]
                || (level[i] == level[grant] && 3'(i) < grant))) begin
                sw_priority_level_ok = 1'b0;
            end
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    sw_priority_level_order_a: assert property (arb_any |-> sw_priority_level_ok)
        else $error("arbiter granted a channel below another eligible one");
    ack_cause_a: assert property (periph_ack != '0 |->
        $onehot(periph_ack) && $past(r_reg.preq) && $past(pbus_ready))
        else $error("peripheral ack without a completed peripheral access");
    read_write_a: assert property ((r_reg.st == dmace_pkg::st_read && done && !err) |=>
        r_reg.st == dmace_pkg::st_write && (mbus_write || pbus_write))
        else $error("source read not followed by destination write");
    count_step_a: assert property ((r_reg.st == dmace_pkg::st_update
        && !c[`DMACE_CTL_CIRC] && !(reg_wr && wok)) |=>
        r_reg.remain[$past(r_reg.sel)] == $past(left))
        else $error("remaining count did not step down by one");
    error_stop_a: assert property ((r_reg.st != dmace_pkg::st_idle
        && r_reg.st != dmace_pkg::st_update && done && err) |=>
        r_reg.flg[$past(ch)][`DMACE_FLG_ERR] && !r_reg.ctl[$past(ch)][`DMACE_CTL_EN]
        && r_reg.st == dmace_pkg::st_idle)
        else $error("bus error did not flag and stop the channel");
    start_enabled_a: assert property ((r_reg.st == dmace_pkg::st_idle && arb_any) |=>
        r_reg.st == dmace_pkg::st_read && $past(r_reg.ctl[grant][`DMACE_CTL_EN])
        && $past(r_reg.remain[grant]) != '0)
        else $error("item started on a disabled or finished channel");
    mem_step_a: assert property ((r_reg.st == dmace_pkg::st_update && c[`DMACE_CTL_MINC]
        && left != '0) |=> r_reg.mcur[$past(r_reg.sel)]
        == $past(r_reg.mcur[r_reg.sel]) + dmace_pkg::item_bytes($past(mw)))
        else $error("memory address did not advance by the item size");
    narrow_write_a: assert property ((mbus_req && mbus_write && mbus_size == `DMACE_W8) |->
        mbus_wdata[31:8] == 24'h00_0000)
        else $error("byte write carries data above the low byte");
    wrap_reload_a: assert property ((r_reg.st == dmace_pkg::st_update && c[`DMACE_CTL_CIRC]
        && left == '0 && !(reg_wr && wok)) |=> r_reg.remain[$past(r_reg.sel)]
        == $past(r_reg.cprog[r_reg.sel]) && r_reg.flg[$past(r_reg.sel)][`DMACE_FLG_FULL])
        else $error("circular pass did not reload the count");

    circ_wrap_c: cover property (r_reg.st == dmace_pkg::st_update && c[`DMACE_CTL_CIRC]
        && left == '0);
    m2m_item_c: cover property (r_reg.st == dmace_pkg::st_update && c[`DMACE_CTL_M2M]);
    bus_error_c: cover property (r_reg.st != dmace_pkg::st_idle && done && err);
    resume_c: cover property (reg_wr && wok && reg_addr[3:2] == `DMACE_SUB_CTL
        && reg_wdata[`DMACE_CTL_EN] && !r_reg.pend[wsel[2:0]]
        && r_reg.remain[wsel[2:0]] != '0);
endmodule
`default_nettype wire

// *** rtl/dmace_params.svh ***
`ifndef DMACE_PARAMS_SVH
`define DMACE_PARAMS_SVH
`define DMACE_CHANNELS 5
`define DMACE_CNT_W 17
`define DMACE_ADDR_W 8
`define DMACE_CTL_W 15
`define DMACE_OFS_FLAG 8'h00
`define DMACE_OFS_CLEAR 8'h04
`define DMACE_SUB_CTL 2'h0
`define DMACE_SUB_CNT 2'h1
`define DMACE_SUB_PBASE 2'h2
`define DMACE_SUB_MBASE 2'h3
`define DMACE_CTL_EN 0
`define DMACE_CTL_FULL_IE 1
`define DMACE_CTL_HALF_IE 2
`define DMACE_CTL_ERR_IE 3
`define DMACE_CTL_DIR 4
`define DMACE_CTL_CIRC 5
`define DMACE_CTL_PINC 6
`define DMACE_CTL_MINC 7
`define DMACE_CTL_PW 8
`define DMACE_CTL_MW 10
`define DMACE_CTL_SW_PRIORITY_LEVEL 12
`define DMACE_CTL_M2M 14
`define DMACE_FLG_FULL 0
`define DMACE_FLG_HALF 1
`define DMACE_FLG_ERR 2
`define DMACE_FLG_STRIDE 4
`define DMACE_W8 2'h0
`define DMACE_W16 2'h1
`define DMACE_W32 2'h2
`endif

// *** rtl/dmace_pkg.sv ***
`include "dmace_params.svh"
`default_nettype none
package dmace_pkg;
    localparam int N = `DMACE_CHANNELS;
    typedef enum logic [1:0] {
        st_idle = 2'h0,
        st_read = 2'h1,
        st_write = 2'h3,
        st_update = 2'h2
    } dmace_state_t;
    typedef struct packed {
        dmace_state_t st;
        logic [2:0] sel;
        logic [N-1:0][`DMACE_CTL_W-1:0] ctl;
        logic [N-1:0][`DMACE_CNT_W-1:0] cprog;
        logic [N-1:0][`DMACE_CNT_W-1:0] remain;
        logic [N-1:0][31:0] pbase;
        logic [N-1:0][31:0] mbase;
        logic [N-1:0][31:0] pcur;
        logic [N-1:0][31:0] mcur;
        logic [N-1:0] pend;
        logic [N-1:0] halt;
        logic [N-1:0][2:0] flg;
        logic [N-1:0] ack;
        logic [31:0] rdata;
        logic mreq;
        logic mwr;
        logic [1:0] msize;
        logic [31:0] maddr;
        logic [31:0] mwdata;
        logic preq;
        logic pwr;
        logic [1:0] psize;
        logic [31:0] paddr;
        logic [31:0] pwdata;
    } dmace_regs_t;
    function automatic logic [31:0] item_bytes(input logic [1:0] w);
        case (w)
            `DMACE_W8: item_bytes = 32'h0000_0001;
            `DMACE_W16: item_bytes = 32'h0000_0002;
            default: item_bytes = 32'h0000_0004;
        endcase
    endfunction
    function automatic logic [31:0] item_mask(input logic [1:0] w);
        case (w)
            `DMACE_W8: item_mask = 32'h0000_00ff;
            `DMACE_W16: item_mask = 32'h0000_ffff;
            default: item_mask = 32'hffff_ffff;
        endcase
    endfunction
endpackage
`default_nettype wire

// *** rtl/dmace_arbiter.sv ***
`include "dmace_params.svh"
`default_nettype none
module dmace_arbiter #(
    parameter int N = `DMACE_CHANNELS
) (
    input wire logic [N-1:0] eligible,
    input wire logic [N-1:0][1:0] level,
    output logic any,
    output logic [2:0] grant
);
    logic [1:0] best;
    // scanning downward with >= lets the lower channel win a tie
    always_comb begin
        any = 1'b0;
        grant = 3'h0;
        best = 2'h0;
        for (int i = N - 1; i >= 0; i--) begin
            if (eligible[i] && (!any || level[i] >= best)) begin
                any = 1'b1;
                grant = 3'(i);
                best = level[i];
            end
        end
    end
endmodule
`default_nettype wire

// *** rtl/dmace_regread.sv ***
`include "dmace_params.svh"
`default_nettype none
module dmace_regread #(
    parameter int N = `DMACE_CHANNELS
) (
    input wire logic [`DMACE_ADDR_W-1:0] addr,
    input wire logic [N-1:0][2:0] flg,
    input wire logic [N-1:0][`DMACE_CTL_W-1:0] ctl,
    input wire logic [N-1:0][`DMACE_CNT_W-1:0] remain,
    input wire logic [N-1:0][31:0] pbase,
    input wire logic [N-1:0][31:0] mbase,
    output logic [31:0] data
);
    logic [3:0] ch;
    assign ch = addr[7:4] - 4'h1;
    always_comb begin
        data = 32'h0000_0000;
        if (addr == `DMACE_OFS_FLAG) begin
            for (int i = 0; i < N; i++) begin
                data[i*`DMACE_FLG_STRIDE +: 3] = flg[i];
            end
        end else if (addr[7:4] != 4'h0 && ch < 4'(N) && addr[1:0] == 2'h0) begin
            case (addr[3:2])
                `DMACE_SUB_CTL: data = 32'(ctl[ch[2:0]]);
                `DMACE_SUB_CNT: data = 32'(remain[ch[2:0]]);
                `DMACE_SUB_PBASE: data = pbase[ch[2:0]];
                default: data = mbase[ch[2:0]];
            endcase
        end
    end
endmodule
`default_nettype wire

// *** sim/dmace_bus_model.sv ***
`default_nettype none
module dmace_bus_model (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic req,
    input wire logic [31:0] addr,
    input wire logic [1:0] lat,
    input wire logic err_inj,
    output logic ready,
    output logic [31:0] rdata,
    output logic error
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] wait_reg;
    logic [31:0] pat;
    // wait count restarts per access, so a slow slave stalls every access alike
    always_ff @(posedge ref_clk) begin
        if (reset || !req || ready) begin
            wait_reg <= 2'h0;
        end else begin
            wait_reg <= wait_reg + 2'h1;
        end
    end
    assign pat = {addr[7:0] ^ 8'h3c, addr[7:0] ^ 8'h96, addr[7:0] ^ 8'h5a, addr[7:0]};
    assign ready = req && (wait_reg >= lat);
    assign error = ready && err_inj;
    // upper bytes carry data on purpose so narrow reads must be masked
    // outside the answer cycle the bus shows inverted data, never stale
    assign rdata = ready ? pat : ~pat;
endmodule
`default_nettype wire

// *** sim/dmace_engine_bench.sv ***
`default_nettype none
module dmace_engine_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic merr = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic [31:0] reg_rdata, mbus_addr, mbus_wdata, mbus_rdata, pbus_addr, pbus_wdata, pbus_rdata;
    logic [4:0] periph_request = 5'h00;
    logic [4:0] periph_ack, channel_irq;
    logic mbus_req, mbus_write, mbus_ready, mbus_error, pbus_req, pbus_write, pbus_ready, pbus_error;
    logic [1:0] mbus_size, pbus_size;
    logic [1:0] mlat = 2'h0;
    logic [1:0] plat = 2'h0;
    int num_errors = 0;
    int compares = 0;
    int seed = 21;
    logic [66:0] exp_q[$];
    logic [31:0] pb, mb, ctl;
    int ord[4] = '{3, 2, 4, 1};
    int lvl[5] = '{0, 0, 2, 3, 2};

    dmace_engine dut (.ref_clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .periph_request, .periph_ack, .channel_irq, .mbus_req, .mbus_write, .mbus_size,
        .mbus_addr, .mbus_wdata, .mbus_ready, .mbus_rdata, .mbus_error, .pbus_req,
        .pbus_write, .pbus_size, .pbus_addr, .pbus_wdata, .pbus_ready, .pbus_rdata, .pbus_error);
    dmace_bus_model mem_m (.ref_clk, .reset, .req(mbus_req), .addr(mbus_addr), .lat(mlat),
        .err_inj(merr), .ready(mbus_ready), .rdata(mbus_rdata), .error(mbus_error));
    dmace_bus_model per_m (.ref_clk, .reset, .req(pbus_req), .addr(pbus_addr), .lat(plat),
        .err_inj(1'b0), .ready(pbus_ready), .rdata(pbus_rdata), .error(pbus_error));

    function automatic logic [31:0] pat(input logic [31:0] a);
        return {a[7:0] ^ 8'h3c, a[7:0] ^ 8'h96, a[7:0] ^ 8'h5a, a[7:0]};
    endfunction
    function automatic logic [31:0] msk(input logic [1:0] w);
        return w == 2'h0 ? 32'h0000_00ff : w == 2'h1 ? 32'h0000_ffff : 32'hffff_ffff;
    endfunction
    function automatic logic [31:0] stp(input logic [1:0] w);
        return w == 2'h0 ? 32'h0000_0001 : w == 2'h1 ? 32'h0000_0002 : 32'h0000_0004;
    endfunction

    task automatic check(input string what, input logic [66:0] seen, input logic [66:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic reg_read(input logic [7:0] a, input logic [31:0] exp);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        check("register read", reg_rdata, exp);
    endtask
    task automatic irq_is(input logic [4:0] exp);
        #1;
        check("channel interrupt", channel_irq, exp);
    endtask
    // source read of item i is implied by the data pattern that reaches the write
    task automatic note_item(input int m, input logic [1:0] pw, input logic [1:0] mw, input int i);
        logic [31:0] pa;
        logic [31:0] ma;
        pa = pb + (m == 1 ? 0 : i) * stp(pw);
        ma = mb + i * stp(mw);
        if (m == 1) begin
            exp_q.push_back({1'b1, pw, pa, pat(ma) & msk(mw) & msk(pw)});
        end else begin
            exp_q.push_back({1'b0, mw, ma, pat(pa) & msk(pw) & msk(mw)});
        end
    endtask
    task automatic prog(input int ch, input logic [31:0] c, input logic [31:0] n);
        logic [7:0] base;
        base = 8'h10 * (ch + 1);
        reg_write(base + 8'h08, pb);
        reg_write(base + 8'h0c, mb);
        reg_write(base + 8'h04, n);
        reg_write(base, c);
    endtask
    task automatic drain();
        for (int k = 0; k < 400 && exp_q.size() != 0; k++) begin
            @(posedge ref_clk);
        end
        repeat (6) @(posedge ref_clk);
        check("pending writes", exp_q.size(), 0);
    endtask
    // one peripheral request, dropped on the cycle after its ack
    task automatic pulse(input int ch);
        periph_request[ch] <= 1'b1;
        for (int k = 0; k < 50; k++) begin
            @(posedge ref_clk);
            #1;
            if (periph_ack[ch] === 1'b1) break;
        end
        check("periph ack", periph_ack[ch], 1'b1);
        @(posedge ref_clk);
        periph_request[ch] <= 1'b0;
        drain();
    endtask
    task automatic idle_req();
        periph_request[0] <= 1'b1;
        repeat (20) @(posedge ref_clk);
        periph_request[0] <= 1'b0;
    endtask

    always @(negedge ref_clk) begin
        if (!reset && ((mbus_req && mbus_write && mbus_ready) || (pbus_req && pbus_write && pbus_ready))) begin
            if (exp_q.size() == 0) begin
                check("unexpected write", 67'h1, 67'h0);
            end else if (mbus_req) begin
                check("memory write", {1'b0, mbus_size, mbus_addr, mbus_wdata}, exp_q.pop_front());
            end else begin
                check("periph write", {1'b1, pbus_size, pbus_addr, pbus_wdata}, exp_q.pop_front());
            end
        end
    end

    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        num_errors++;
        give_verdict();
    end

    initial begin
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        reg_read(8'h14, 32'h0000_0000);
        reg_read(8'h08, 32'h0000_0000);
        // every direction against every width pair, random bases and slave latency
        for (int m = 0; m < 3; m++) begin
            for (int pw = 0; pw < 3; pw++) begin
                for (int mw = 0; mw < 3; mw++) begin
                    pb = $random(seed) & 32'h0000_fff0;
                    mb = ($random(seed) & 32'h0000_fff0) | 32'h0002_0000;
                    mlat <= 2'($random(seed));
                    plat <= 2'($random(seed));
                    ctl = 32'h0000_0081 | ((m != 1) << 6) | (pw << 8) | (mw << 10)
                        | ((m == 1) << 4) | ((m == 2) << 14);
                    note_item(m, pw[1:0], mw[1:0], 0);
                    note_item(m, pw[1:0], mw[1:0], 1);
                    prog(0, ctl, 32'h0000_0002);
                    periph_request[0] <= (m != 2);
                    drain();
                    periph_request[0] <= 1'b0;
                    reg_read(8'h14, 32'h0000_0000);
                    reg_read(8'h00, 32'h0000_0003);
                    reg_write(8'h10, ctl & ~32'h0000_0001);
                    reg_write(8'h04, 32'h0000_0007);
                end
            end
        end
        $display("test widths and directions done");
        mlat <= 2'h1;
        plat <= 2'h0;
        for (int k = 0; k < 4; k++) begin
            pb = 32'h0000_1000 * ord[k];
            mb = 32'h0000_8000 + 32'h0000_0100 * ord[k];
            exp_q.push_back({1'b0, 2'h2, mb, pat(pb)});
        end
        for (int ch = 1; ch < 5; ch++) begin
            pb = 32'h0000_1000 * ch;
            mb = 32'h0000_8000 + 32'h0000_0100 * ch;
            prog(ch, 32'h0000_0ac1 | (lvl[ch] << 12), 32'h0000_0001);
        end
        periph_request <= 5'h1e;
        drain();
        periph_request <= 5'h00;
        for (int ch = 1; ch < 5; ch++) begin
            reg_write(8'h10 * (ch + 1), 32'h0000_0000);
        end
        reg_write(8'h04, 32'hffff_ffff);
        $display("test priority done");
        pb = 32'h0000_0400;
        mb = 32'h0000_0800;
        prog(0, 32'h0000_00c3, 32'h0000_0004);
        for (int i = 0; i < 4; i++) begin
            note_item(0, 2'h0, 2'h0, i);
            pulse(0);
            if (i == 1) begin
                reg_write(8'h10, 32'h0000_00c2);
                idle_req();
                reg_read(8'h14, 32'h0000_0002);
                reg_read(8'h00, 32'h0000_0002);
                irq_is(5'h00);
                reg_write(8'h10, 32'h0000_00c3);
            end
        end
        reg_read(8'h00, 32'h0000_0003);
        irq_is(5'h01);
        reg_write(8'h04, 32'h0000_0007);
        irq_is(5'h00);
        reg_write(8'h10, 32'h0000_00c2);
        reg_write(8'h10, 32'h0000_00c3);
        idle_req();
        reg_write(8'h10, 32'h0000_00c2);
        reg_write(8'h14, 32'h0000_0001);
        note_item(0, 2'h0, 2'h0, 0);
        reg_write(8'h10, 32'h0000_00e3);
        pulse(0);
        note_item(0, 2'h0, 2'h0, 0);
        pulse(0);
        reg_read(8'h14, 32'h0000_0001);
        reg_write(8'h10, 32'h0000_0000);
        reg_write(8'h04, 32'h0000_0007);
        $display("test stop and resume done");
        merr <= 1'b1;
        prog(0, 32'h0000_4ac9, 32'h0000_0002);
        repeat (20) @(posedge ref_clk);
        reg_read(8'h00, 32'h0000_0004);
        reg_read(8'h10, 32'h0000_4ac8);
        irq_is(5'h01);
        merr <= 1'b0;
        reg_write(8'h04, 32'h0000_0007);
        reg_write(8'h10, 32'h0000_4ac9);
        repeat (20) @(posedge ref_clk);
        check("pending writes", exp_q.size(), 0);
        $display("test bus error done");
        give_verdict();
    end
endmodule
`default_nettype wire
